// ---- mscl_core.v ----
// sensor measurement and pidf closed-loop core for a brushed motor
//
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/1ps
`include "mscl_regs.vh"
module mscl_core
#(
  parameter TICK_CYC = `MSCL_TICK_CYC   // cycles per 1ms control tick
)
(
  input  wire        ref_clk_in,        // 250 MHz clock
  input  wire        rst_in,            // async reset, active high
  input  wire        psel_in,           // apb select
  input  wire        penable_in,        // apb access phase
  input  wire        pwrite_in,         // apb direction
  input  wire [11:0] paddr_in,          // apb byte address
  input  wire [31:0] pwdata_in,         // apb write data
  output reg  [31:0] prdata_out,        // apb read data
  output reg         pready_out,        // apb ready
  output reg         pslverr_out,       // apb error, unmapped address
  input  wire        quad_a_in,         // encoder channel a pin
  input  wire        quad_b_in,         // encoder channel b pin
  input  wire        pulse_width_in,    // pulse-width encoder pin
  input  wire        tach_in,           // tachometer pulse pin
  input  wire [9:0]  adc_value_in,      // converter sample, 0..1023
  input  wire        adc_strobe_in,     // converter sample valid pulse
  output reg  [10:0] bridge_cmd_out,    // signed bridge drive
  output reg         led_fwd_out,       // forward led, never inverted
  output reg         led_rev_out        // reverse led, never inverted
);

  // counts derived from the tick length
  localparam [31:0] TICK_N  = TICK_CYC;               // cycles per tick
  localparam [7:0]  RAMP_N  = `MSCL_RAMP_MS;          // ticks per ramp
  localparam [7:0]  VEL_N   = `MSCL_VELWIN_MS;        // ticks per window

  // software registers
  reg  [31:0] ctrl_reg;       // mode, invert, phase, sensor select
  reg  [31:0] target_reg;     // signed set point
  reg  [10:0] ol_cmd_reg;     // open-loop signed demand
  reg  [10:0] ol_ramp_reg;    // open-loop step per ramp interval
  reg  [10:0] cl_ramp_reg;    // closed-loop step per ramp interval
  reg  [15:0] kp_reg;         // gains, unsigned p/i/d, signed f
  reg  [15:0] ki_reg;
  reg  [15:0] kd_reg;
  reg  [15:0] kf_reg;
  reg  [31:0] izone_reg;      // integral window in sensor units

  // synchronisers: two flops before any logic reads a pin
  reg  [3:0]  sync1_reg;      // first stage, only read by second
  reg  [3:0]  sync2_reg;      // second stage
  reg  [3:0]  prev_reg;       // delayed copy for edge detection
  reg  [9:0]  adc_s1_reg;
  reg  [9:0]  adc_s2_reg;
  reg         stb_s1_reg;
  reg         stb_s2_reg;
  reg         stb_d_reg;

  // measurement state
  reg  [31:0] quad_pos_reg;   // 4x edge count
  reg  [31:0] aenc_pos_reg;   // unwrapped analog encoder position
  reg  [9:0]  adc_last_reg;   // last captured converter value
  reg  [31:0] pw_high_reg;    // high cycles in current period
  reg  [31:0] pw_period_reg;  // cycles in current period
  reg  [31:0] pw_pos_reg;     // duty scaled to 4096
  reg  [31:0] tach_cyc_reg;   // cycles since last tach pulse
  reg  [31:0] tach_per_reg;   // last measured tach period
  reg  [31:0] tach_vel_reg;

  // timing
  reg  [31:0] tick_cnt_reg;   // cycles inside a tick
  reg         tick_reg;       // one-cycle 1ms tick
  reg  [7:0]  ramp_cnt_reg;   // ticks inside a ramp interval
  reg  [7:0]  vel_cnt_reg;    // ticks inside a velocity window
  reg  [31:0] win_pos_reg;    // position at start of window
  reg  [31:0] vel_reg;        // reported velocity

  // closed-loop state
  reg  [31:0] iacc_reg;       // integral sum
  reg  [31:0] prev_meas_reg;  // measurement from previous tick
  reg  [31:0] err_reg;        // last error, readable
  reg  [10:0] demand_reg;     // pidf result, saturated
  reg  [10:0] out_reg;        // ramped, non-inverted output
  reg         first_reg;      // first pass since closed loop enabled

  wire [2:0]  sel   = ctrl_reg[`MSCL_CTRL_SEL_HI:`MSCL_CTRL_SEL_LO];
  wire        clm   = ctrl_reg[`MSCL_CTRL_CL_BIT];
  wire        velm  = ctrl_reg[`MSCL_CTRL_VELMODE];
  wire        inv   = ctrl_reg[`MSCL_CTRL_INVERT];
  wire        phase = ctrl_reg[`MSCL_CTRL_PHASE];

  // synchronised pins: a, b, pulse width, tach
  wire [3:0]  pin_s   = sync2_reg;
  wire        tach_rise = pin_s[3] & ~prev_reg[3];
  wire        pw_rise   = pin_s[2] & ~prev_reg[2];
  wire        adc_new   = stb_s2_reg & ~stb_d_reg;

  // quadrature step decode, every single-channel edge counts
  wire        q_chg = (pin_s[0] ^ prev_reg[0]) ^ (pin_s[1] ^ prev_reg[1]);
  wire        q_up  = prev_reg[0] ^ pin_s[1];

  // analog encoder wrap detection by half-scale jump
  wire [10:0] adc_diff = {1'b0, adc_s2_reg} - {1'b0, adc_last_reg};
  wire signed [10:0] adc_d = adc_diff;

  // raw native-unit position of the selected sensor
  reg  [31:0] raw_pos;
  always @*
  begin
    case (sel)
      `MSCL_SEL_QUAD: raw_pos = quad_pos_reg;
      `MSCL_SEL_POT:  raw_pos = {22'h000000, adc_last_reg};
      `MSCL_SEL_AENC: raw_pos = aenc_pos_reg;
      `MSCL_SEL_PWM:  raw_pos = pw_pos_reg;
      default:        raw_pos = quad_pos_reg;
    endcase
  end

  // sensor phase negates the reading; invert is not folded in here
  wire [31:0] pos_m = phase ? (32'h0 - raw_pos) : raw_pos;
  wire [31:0] vel_m = (sel == `MSCL_SEL_TACH) ?
                      (phase ? 32'h0 - tach_vel_reg : tach_vel_reg) : vel_reg;
  wire [31:0] meas  = velm ? vel_m : pos_m;

  // pidf arithmetic, evaluated combinationally and latched on tick
  wire signed [31:0] err   = $signed(target_reg) - $signed(meas);
  wire [31:0]        abse  = err[31] ? (32'h0 - err) : err;
  wire               in_iz = (izone_reg == 32'h0) || (abse < izone_reg);
  wire signed [31:0] iacc_n = first_reg ? 32'sh0 :
                              (in_iz ? $signed(iacc_reg) + err : 32'sh0);
  wire signed [31:0] derr  = first_reg ? 32'sh0 :
                             $signed(prev_meas_reg) - $signed(meas);
  wire signed [47:0] p_t = err * $signed({1'b0, kp_reg});
  wire signed [47:0] i_t = iacc_n * $signed({1'b0, ki_reg});
  wire signed [47:0] d_t = derr * $signed({1'b0, kd_reg});
  wire signed [47:0] f_t = $signed(target_reg) * $signed(kf_reg);
  wire signed [49:0] sum = p_t + i_t + d_t + f_t;
  wire signed [10:0] sat = (sum > 50'sd1023)  ? `MSCL_OUT_MAX :
                           (sum < -50'sd1023) ? -`MSCL_OUT_MAX :
                           sum[10:0];

  // ramp: move output toward demand by at most the step; a zero step jumps straight there
  wire [10:0] goal = clm ? demand_reg : ol_cmd_reg;
  wire [10:0] step = clm ? cl_ramp_reg : ol_ramp_reg;
  wire signed [11:0] gap = $signed({goal[10], goal}) -
                           $signed({out_reg[10], out_reg});
  wire signed [11:0] stp = $signed({1'b0, step});
  wire [10:0] ramped = (step == 11'h0) ? goal :
                       (gap > stp)  ? out_reg + step :
                       (gap < -stp) ? out_reg - step : goal;

  // open-loop demand keeps the low 11 bits, with -1024 clipped to -1023
  wire signed [10:0] ol_sat = ($signed(pwdata_in[10:0]) < -`MSCL_OUT_MAX) ?
                              -`MSCL_OUT_MAX : pwdata_in[10:0];

  wire wr = psel_in & penable_in & pwrite_in;

  // pin and converter synchronisers
  always @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      sync1_reg  <= 4'h0;
      sync2_reg  <= 4'h0;
      prev_reg   <= 4'h0;
      adc_s1_reg <= 10'h000;
      adc_s2_reg <= 10'h000;
      stb_s1_reg <= 1'b0;
      stb_s2_reg <= 1'b0;
      stb_d_reg  <= 1'b0;
    end
    else
    begin
      sync1_reg  <= {tach_in, pulse_width_in, quad_b_in, quad_a_in};
      sync2_reg  <= sync1_reg;
      prev_reg   <= sync2_reg;
      // sample bus is held stable by the converter around its strobe
      adc_s1_reg <= adc_value_in;
      adc_s2_reg <= adc_s1_reg;
      stb_s1_reg <= adc_strobe_in;
      stb_s2_reg <= stb_s1_reg;
      stb_d_reg  <= stb_s2_reg;
    end
  end

  // sensor measurement: quadrature, analog unwrap, pulse width, tach
  always @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      quad_pos_reg  <= 32'h0;
      aenc_pos_reg  <= 32'h0;
      adc_last_reg  <= 10'h000;
      pw_high_reg   <= 32'h0;
      pw_period_reg <= 32'h0;
      pw_pos_reg    <= 32'h0;
      tach_cyc_reg  <= 32'h0;
      tach_per_reg  <= 32'h0;
    end
    else
    begin
      // a glitch changing both channels at once is ignored
      if (q_chg)
        quad_pos_reg <= q_up ? quad_pos_reg + 32'h1 : quad_pos_reg - 32'h1;
      if (adc_new)
      begin
        // a jump over half scale is taken as a wrap, continuing onward
        if (adc_d < -11'sd512)
          aenc_pos_reg <= aenc_pos_reg + {{21{adc_d[10]}}, adc_d} + 32'd1024;
        else if (adc_d > 11'sd511)
          aenc_pos_reg <= aenc_pos_reg + {{21{adc_d[10]}}, adc_d} - 32'd1024;
        else
          aenc_pos_reg <= aenc_pos_reg + {{21{adc_d[10]}}, adc_d};
        adc_last_reg <= adc_s2_reg;
      end
      // duty measured once per period; high time times 4096 divided by period
      if (pw_rise)
      begin
        if (pw_period_reg != 32'h0)
          pw_pos_reg <= (pw_high_reg * `MSCL_PWM_FULL) / pw_period_reg;
        // the rising cycle itself is already high time
        pw_high_reg   <= 32'h1;
        pw_period_reg <= 32'h1;
      end
      else
      begin
        pw_period_reg <= pw_period_reg + 32'h1;
        if (pin_s[2])
          pw_high_reg <= pw_high_reg + 32'h1;
      end
      // tach count saturates; a stalled rotor keeps its last period and velocity
      if (tach_rise)
      begin
        tach_per_reg <= tach_cyc_reg;
        tach_cyc_reg <= 32'h1;
      end
      else if (tach_cyc_reg != 32'hffff_ffff)
        tach_cyc_reg <= tach_cyc_reg + 32'h1;
    end
  end

  // tach velocity: rotations per window scaled by 1024 while 1024 times the window cycles fits in 32 bits
  wire [63:0] tach_num = {32'h0, `MSCL_TACH_ROT} * {32'h0, TICK_N} *
                         {56'h0, VEL_N};
  always @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
      tach_vel_reg <= 32'h0;
    else if (tick_reg)
      tach_vel_reg <= (tach_per_reg == 32'h0) ? 32'h0 :
                      tach_num[31:0] / tach_per_reg;
  end

  // 1ms tick, ramp interval and velocity window
  always @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      tick_cnt_reg <= 32'h0;
      tick_reg     <= 1'b0;
      ramp_cnt_reg <= 8'h0;
      vel_cnt_reg  <= 8'h0;
      win_pos_reg  <= 32'h0;
      vel_reg      <= 32'h0;
    end
    else
    begin
      tick_reg <= (tick_cnt_reg == TICK_N - 32'h1);
      tick_cnt_reg <= (tick_cnt_reg == TICK_N - 32'h1) ? 32'h0 :
                      tick_cnt_reg + 32'h1;
      if (tick_reg)
      begin
        ramp_cnt_reg <= (ramp_cnt_reg == RAMP_N - 8'h1) ? 8'h0 :
                        ramp_cnt_reg + 8'h1;
        if (vel_cnt_reg == VEL_N - 8'h1)
        begin
          vel_cnt_reg <= 8'h0;
          vel_reg     <= pos_m - win_pos_reg;
          win_pos_reg <= pos_m;
        end
        else
          vel_cnt_reg <= vel_cnt_reg + 8'h1;
      end
    end
  end

  // closed loop stepped once per tick, output once per ramp interval
  always @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      iacc_reg       <= 32'h0;
      prev_meas_reg  <= 32'h0;
      err_reg        <= 32'h0;
      demand_reg     <= 11'h0;
      out_reg        <= 11'h0;
      first_reg      <= 1'b1;
      bridge_cmd_out <= 11'h0;
      led_fwd_out    <= 1'b0;
      led_rev_out    <= 1'b0;
    end
    else
    begin
      if (!clm)
        first_reg <= 1'b1;
      else if (tick_reg)
      begin
        iacc_reg      <= iacc_n;
        prev_meas_reg <= meas;
        err_reg       <= err;
        demand_reg    <= sat;
        first_reg     <= 1'b0;
      end
      if (tick_reg && ramp_cnt_reg == RAMP_N - 8'h1)
        out_reg <= ramped;
      // invert flips only the bridge; leds follow the true sense
      bridge_cmd_out <= inv ? 11'h0 - out_reg : out_reg;
      led_fwd_out    <= ~out_reg[10] & (out_reg != 11'h0);
      led_rev_out    <= out_reg[10];
    end
  end

  // apb register writes
  always @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ctrl_reg    <= `MSCL_CTRL_RESET;
      target_reg  <= 32'h0;
      ol_cmd_reg  <= 11'h0;
      ol_ramp_reg <= 11'h0;
      cl_ramp_reg <= 11'h0;
      kp_reg      <= 16'h0;
      ki_reg      <= 16'h0;
      kd_reg      <= 16'h0;
      kf_reg      <= 16'h0;
      izone_reg   <= 32'h0;
    end
    else if (wr)
    begin
      case (paddr_in)
        `MSCL_CTRL_ADDR:    ctrl_reg    <= {25'h0, pwdata_in[6:0]};
        `MSCL_TARGET_ADDR:  target_reg  <= pwdata_in;
        `MSCL_OL_CMD_ADDR:  ol_cmd_reg  <= ol_sat;
        `MSCL_OL_RAMP_ADDR: ol_ramp_reg <= pwdata_in[10:0];
        `MSCL_CL_RAMP_ADDR: cl_ramp_reg <= pwdata_in[10:0];
        `MSCL_KP_ADDR:      kp_reg      <= pwdata_in[15:0];
        `MSCL_KI_ADDR:      ki_reg      <= pwdata_in[15:0];
        `MSCL_KD_ADDR:      kd_reg      <= pwdata_in[15:0];
        `MSCL_KF_ADDR:      kf_reg      <= pwdata_in[15:0];
        `MSCL_IZONE_ADDR:   izone_reg   <= pwdata_in;
        default:            ctrl_reg    <= ctrl_reg;
      endcase
    end
  end

  // apb read mux and zero-wait answer
  reg [31:0] rd;
  reg        hit;
  always @*
  begin
    hit = 1'b1;
    case (paddr_in)
      `MSCL_CTRL_ADDR:    rd = ctrl_reg;
      `MSCL_TARGET_ADDR:  rd = target_reg;
      `MSCL_OL_CMD_ADDR:  rd = {{21{ol_cmd_reg[10]}}, ol_cmd_reg};
      `MSCL_OL_RAMP_ADDR: rd = {21'h0, ol_ramp_reg};
      `MSCL_CL_RAMP_ADDR: rd = {21'h0, cl_ramp_reg};
      `MSCL_KP_ADDR:      rd = {16'h0, kp_reg};
      `MSCL_KI_ADDR:      rd = {16'h0, ki_reg};
      `MSCL_KD_ADDR:      rd = {16'h0, kd_reg};
      `MSCL_KF_ADDR:      rd = {16'h0, kf_reg};
      `MSCL_IZONE_ADDR:   rd = izone_reg;
      `MSCL_POS_ADDR:     rd = pos_m;
      `MSCL_VEL_ADDR:     rd = vel_m;
      `MSCL_OUT_ADDR:     rd = {{21{out_reg[10]}}, out_reg};
      `MSCL_IACC_ADDR:    rd = iacc_reg;
      `MSCL_ERR_ADDR:     rd = err_reg;
      `MSCL_ADC_ADDR:     rd = {22'h0, adc_s2_reg};
      default:
      begin
        rd  = 32'h0;
        hit = 1'b0;
      end
    endcase
  end

  // answer in the access cycle after one registered setup cycle
  always @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      prdata_out  <= 32'h0;
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end
    else
    begin
      pready_out  <= psel_in & ~penable_in;
      pslverr_out <= psel_in & ~penable_in & ~hit;
      prdata_out  <= (psel_in & ~penable_in & ~pwrite_in) ? rd : 32'h0;
    end
  end

endmodule // mscl_core

// ---- mscl_regs.vh ----
// register offsets, field positions, reset values and timing counts
`ifndef MSCL_REGS_VH
`define MSCL_REGS_VH
// register byte offsets
`define MSCL_CTRL_ADDR      12'h000
`define MSCL_TARGET_ADDR    12'h004
`define MSCL_OL_CMD_ADDR    12'h008
`define MSCL_OL_RAMP_ADDR   12'h00c
`define MSCL_CL_RAMP_ADDR   12'h010
`define MSCL_KP_ADDR        12'h014
`define MSCL_KI_ADDR        12'h018
`define MSCL_KD_ADDR        12'h01c
`define MSCL_KF_ADDR        12'h020
`define MSCL_IZONE_ADDR     12'h024
`define MSCL_POS_ADDR       12'h028
`define MSCL_VEL_ADDR       12'h02c
`define MSCL_OUT_ADDR       12'h030
`define MSCL_IACC_ADDR      12'h034
`define MSCL_ERR_ADDR       12'h038
`define MSCL_ADC_ADDR       12'h03c
// control register fields
`define MSCL_CTRL_CL_BIT    0
`define MSCL_CTRL_VELMODE   1
`define MSCL_CTRL_INVERT    2
`define MSCL_CTRL_PHASE     3
`define MSCL_CTRL_SEL_LO    4
`define MSCL_CTRL_SEL_HI    6
`define MSCL_CTRL_RESET     32'h0000_0000
// sensor selections
`define MSCL_SEL_QUAD       3'h0
`define MSCL_SEL_POT        3'h1
`define MSCL_SEL_AENC       3'h2
`define MSCL_SEL_PWM        3'h3
`define MSCL_SEL_TACH       3'h4
// scaling constants
`define MSCL_OUT_MAX        11'sd1023
`define MSCL_ADC_MAX        10'h3ff
`define MSCL_PWM_FULL       32'd4096
`define MSCL_TACH_ROT       32'd1024
// timing figures and derived cycle counts at 250 MHz
`define MSCL_CLK_MHZ        250
`define MSCL_TICK_US        1000
`define MSCL_RAMP_MS        10
`define MSCL_VELWIN_MS      100
`define MSCL_TICK_CYC       (`MSCL_TICK_US * `MSCL_CLK_MHZ)
`endif

// ---- mscl_sensor_model.sv ----
// sensor-side model: quadrature pins, converter samples, pwm and tach pulses
`timescale 1ns/1ps
module mscl_sensor_model
#(
  parameter PW_PER   = 400,  // pulse-width frame length in cycles
  parameter PW_HI    = 100,  // high time, a quarter of the frame
  parameter TACH_PER = 400   // cycles between tach rising edges
)
(
  input  wire       ref_clk_in,     // bench clock
  output reg        quad_a_out,     // encoder channel a
  output reg        quad_b_out,     // encoder channel b
  output reg        pulse_width_out,// pulse-width encoder line
  output reg        tach_out,       // tach pulse line
  output reg  [9:0] adc_value_out,  // converter value
  output reg        adc_strobe_out  // converter valid pulse
);
  integer ph;   // gray-code phase index
  integer cnt;  // free-running frame counter
  reg [1:0] gray [0:3];  // b leads a when moving forward
  initial
  begin
    gray[0] = 2'b00; gray[1] = 2'b01; gray[2] = 2'b11; gray[3] = 2'b10;
    ph = 0; cnt = 0;
    {quad_a_out, quad_b_out} = 2'b00;
    pulse_width_out = 1'b0; tach_out = 1'b0;
    adc_value_out = 10'h155; adc_strobe_out = 1'b0;
  end
  // one edge per step; held long enough to clear the two-flop sync
  task quad(input integer n, input integer fwd);
    integer i;
    for (i = 0; i < n; i = i + 1)
    begin
      @(posedge ref_clk_in);
      ph = fwd ? ph + 1 : ph + 3;
      {quad_a_out, quad_b_out} <= gray[ph % 4];
      repeat (6) @(posedge ref_clk_in);
    end
  endtask
  // value is only meaningful with the strobe; between strobes it flips
  task adc(input [9:0] v);
    @(posedge ref_clk_in);
    adc_value_out  <= v;
    adc_strobe_out <= 1'b1;
    repeat (4) @(posedge ref_clk_in);
    adc_value_out  <= ~v;
    adc_strobe_out <= 1'b0;
    repeat (8) @(posedge ref_clk_in);
  endtask
  // pwm and tach run free, as real sensors do
  always @(posedge ref_clk_in)
  begin
    cnt <= (cnt + 1) % PW_PER;
    pulse_width_out <= (cnt < PW_HI);
    tach_out <= ((cnt % TACH_PER) < 8);
  end
endmodule // mscl_sensor_model

// ---- mscl_core_sva.sv ----
// port-level checker for the apb slave and the bridge outputs
`timescale 1ns/1ps
module mscl_core_sva (
  input wire        ref_clk_in,
  input wire        rst_in,
  input wire        psel_in,
  input wire        penable_in,
  input wire        pwrite_in,
  input wire [31:0] prdata_out,
  input wire        pready_out,
  input wire        pslverr_out,
  input wire [10:0] bridge_cmd_out,
  input wire        led_fwd_out,
  input wire        led_rev_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  property p_ans; psel_in && !penable_in |=> pready_out; endproperty
  a_ans: assert property (p_ans) else $error("no ready after setup");
  property p_acc; pready_out |-> psel_in && penable_in; endproperty
  a_acc: assert property (p_acc) else $error("ready outside access");
  property p_one; pready_out |=> !pready_out; endproperty
  a_one: assert property (p_one) else $error("ready held too long");
  property p_err; pslverr_out |-> pready_out; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_rz; pready_out && pslverr_out && !pwrite_in
    |-> prdata_out == 32'h0; endproperty
  a_rz: assert property (p_rz) else $error("refused read not zero");
  property p_rng; bridge_cmd_out != 11'h400; endproperty
  a_rng: assert property (p_rng) else $error("drive out of range");
  property p_led; !(led_fwd_out && led_rev_out); endproperty
  a_led: assert property (p_led) else $error("both leds lit");
  property p_idle; (bridge_cmd_out == 11'h000) [*3]
    |-> !led_fwd_out && !led_rev_out; endproperty
  a_idle: assert property (p_idle) else $error("led lit at neutral");
  property p_rst; $fell(rst_in) |-> bridge_cmd_out == 11'h000
    && !pready_out; endproperty
  a_rst: assert property (p_rst) else $error("outputs busy after reset");
  c_err: cover property (pready_out && pslverr_out);
  c_wr:  cover property (pready_out && pwrite_in);
  c_rev: cover property (led_rev_out);
endmodule // mscl_core_sva
bind mscl_core mscl_core_sva chk_u (.ref_clk_in(ref_clk_in),
  .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out),
  .bridge_cmd_out(bridge_cmd_out), .led_fwd_out(led_fwd_out),
  .led_rev_out(led_rev_out));

// ---- test_motor_sensor_closed_loop_units.sv ----
// self-checking bench for the sensor and closed-loop core
`timescale 1ns/1ps
`include "mscl_regs.vh"
module test_motor_sensor_closed_loop_units;
  localparam TK = 20;  // shortened control tick
  reg clk = 1'b0, rst = 1'b1;  // clock and reset
  reg psel = 1'b0, pen = 1'b0, pwr = 1'b0;  // apb request
  reg [11:0] pa = 12'h000;  // apb address
  reg [31:0] pd = 32'h0;    // apb write data
  wire [31:0] prd;          // apb read data
  wire rdy, serr, qa, qb, pw, tc, stb, lf, lr;
  wire [9:0] av;            // converter value
  wire [10:0] br;           // bridge drive
  integer bad_count = 0, checks_done = 0, cyc = 0, seed = 32'hc4aa;
  integer i, v, mx;         // loop and model scratch
  reg [31:0] q, q2;         // read results
  reg last_err;             // error flag of the last transfer
  always #2 clk = ~clk;
  mscl_core #(.TICK_CYC(TK)) dut_u (.ref_clk_in(clk), .rst_in(rst),
    .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa),
    .pwdata_in(pd), .prdata_out(prd), .pready_out(rdy),
    .pslverr_out(serr), .quad_a_in(qa), .quad_b_in(qb),
    .pulse_width_in(pw), .tach_in(tc), .adc_value_in(av),
    .adc_strobe_in(stb), .bridge_cmd_out(br), .led_fwd_out(lf),
    .led_rev_out(lr));
  mscl_sensor_model sm_u (.ref_clk_in(clk), .quad_a_out(qa),
    .quad_b_out(qb), .pulse_width_out(pw), .tach_out(tc),
    .adc_value_out(av), .adc_strobe_out(stb));
  task test_done;
    if (bad_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // hang guard, well above the expected run length
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 90000)
    begin
      bad_count = bad_count + 1;
      test_done;
    end
  end
  task chk(input [31:0] g, input [31:0] e);
    checks_done = checks_done + 1;
    if (g !== e)
    begin
      bad_count = bad_count + 1;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // one apb transfer; waits for ready, no fixed latency assumed
  task apb(input w, input [11:0] a, input [31:0] d);
    integer n;
    @(posedge clk);
    psel <= 1'b1; pen <= 1'b0; pwr <= w; pa <= a; pd <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    @(posedge clk);
    while (rdy !== 1'b1 && n < 50)
    begin
      n = n + 1;
      @(posedge clk);
    end
    q = prd; last_err = serr;
    psel <= 1'b0; pen <= 1'b0;
  endtask
  task wr(input [11:0] a, input [31:0] d);
    apb(1'b1, a, d);
  endtask
  task reset_dut;
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
  endtask
  // reads the ramped output and bounds every step between polls
  task ramp_watch(input integer lim, input integer fin, input integer n);
    integer k, p, c;
    apb(1'b0, `MSCL_OUT_ADDR, 0);
    p = $signed(q[10:0]);
    for (k = 0; k < n; k = k + 1)
    begin
      repeat (17) @(posedge clk);
      apb(1'b0, `MSCL_OUT_ADDR, 0);
      c = $signed(q[10:0]);
      chk((c - p > lim || p - c > lim), 0);
      p = c;
    end
    chk(q[10:0], fin[10:0]);
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, `MSCL_CTRL_ADDR, 0); chk(q, `MSCL_CTRL_RESET);
    apb(1'b0, 12'h040, 0); chk({q[30:0], last_err}, 1);
    for (i = 0; i < 3; i = i + 1)
    begin
      v = $random(seed);
      wr(`MSCL_KP_ADDR + 4 * i, v);
      apb(1'b0, `MSCL_KP_ADDR + 4 * i, 0); chk(q[15:0], v[15:0]);
    end
    wr(`MSCL_POS_ADDR, 32'h55);
    apb(1'b0, `MSCL_POS_ADDR, 0); chk(q, 0);
    // quadrature: every edge counts, phase negates, invert does not
    sm_u.quad(40, 1); sm_u.quad(12, 0);
    apb(1'b0, `MSCL_POS_ADDR, 0); chk(q, 28);
    wr(`MSCL_CTRL_ADDR, 32'h8); sm_u.quad(4, 1);
    apb(1'b0, `MSCL_POS_ADDR, 0); chk(q, -32);
    wr(`MSCL_CTRL_ADDR, 32'hc); sm_u.quad(4, 1);
    apb(1'b0, `MSCL_POS_ADDR, 0); chk(q, -36);
    wr(`MSCL_CTRL_ADDR, 0);
    // quiet windows, a burst, then three reads exactly one window apart:
    // the windows they see together must hold the whole burst
    repeat (4100) @(posedge clk);
    sm_u.quad(12, 1);
    mx = 0;
    for (i = 0; i < 3; i = i + 1)
    begin
      apb(1'b0, `MSCL_VEL_ADDR, 0);
      mx = mx + $signed(q);
      repeat (1997) @(posedge clk);
    end
    chk(mx, 12);
    wr(`MSCL_CTRL_ADDR, 32'h10); sm_u.adc(10'd700);
    apb(1'b0, `MSCL_POS_ADDR, 0); chk(q, 700);
    reset_dut;
    wr(`MSCL_CTRL_ADDR, 32'h20);
    sm_u.adc(100); sm_u.adc(400); sm_u.adc(700); sm_u.adc(1000);
    sm_u.adc(200);
    apb(1'b0, `MSCL_POS_ADDR, 0); chk(q, 1224);
    wr(`MSCL_CTRL_ADDR, 32'h30); repeat (3000) @(posedge clk);
    apb(1'b0, `MSCL_POS_ADDR, 0); chk(q, 4096 * 100 / 400);
    wr(`MSCL_CTRL_ADDR, 32'h40); repeat (3000) @(posedge clk);
    apb(1'b0, `MSCL_VEL_ADDR, 0); chk(q, 1024 * TK * 100 / 400);
    // open-loop ramp up, invert, then ramp through zero to reverse
    reset_dut;
    wr(`MSCL_OL_RAMP_ADDR, 10); wr(`MSCL_OL_CMD_ADDR, 100);
    ramp_watch(10, 100, 150);
    chk({br, lf, lr}, {11'd100, 2'b10});
    wr(`MSCL_CTRL_ADDR, 32'h4); repeat (50) @(posedge clk);
    chk({br, lf, lr}, {-11'sd100, 2'b10});
    wr(`MSCL_CTRL_ADDR, 0); wr(`MSCL_OL_CMD_ADDR, -100);
    ramp_watch(10, -100, 250);
    chk({br, lf, lr}, {-11'sd100, 2'b01});
    // closed loop on quadrature, position zero after reset
    reset_dut;
    wr(`MSCL_KP_ADDR, 2); wr(`MSCL_TARGET_ADDR, 50);
    wr(`MSCL_CTRL_ADDR, 1); repeat (200) @(posedge clk);
    apb(1'b0, `MSCL_ERR_ADDR, 0); chk(q, 50);
    apb(1'b0, `MSCL_OUT_ADDR, 0); chk(q[10:0], 100);
    wr(`MSCL_KP_ADDR, 0); wr(`MSCL_KF_ADDR, 3); repeat (200) @(posedge clk);
    apb(1'b0, `MSCL_OUT_ADDR, 0); chk(q[10:0], 150);
    wr(`MSCL_KF_ADDR, 0); wr(`MSCL_KI_ADDR, 1);
    apb(1'b0, `MSCL_IACC_ADDR, 0); q2 = q;
    repeat (97) @(posedge clk);
    apb(1'b0, `MSCL_IACC_ADDR, 0); chk(q - q2, 5 * 50);
    wr(`MSCL_IZONE_ADDR, 10); repeat (100) @(posedge clk);
    apb(1'b0, `MSCL_IACC_ADDR, 0); chk(q, 0);
    wr(`MSCL_KI_ADDR, 0); wr(`MSCL_IZONE_ADDR, 0);
    repeat (400) @(posedge clk);  // let the output settle at zero demand
    wr(`MSCL_CL_RAMP_ADDR, 3); wr(`MSCL_TARGET_ADDR, 9);
    wr(`MSCL_KP_ADDR, 1);
    ramp_watch(3, 9, 60);
    test_done;
  end
endmodule // test_motor_sensor_closed_loop_units
